// ### src/uart_irq_pkg.sv
// Summary of operation
// - mask gates rx, tx, line, modem sources
// - rx available follows trigger level crossing with fifo on, else receive ready
// - receive ready sets on entry, clears empty
// - fifo on, mask 0-3 and 5 clear: polled
// - line state bit 1 flags overrun
// - bits 2-4 show head character errors
// - bit 5 holding empty, 6 all empty
// - bit 7 any errored character in fifo
// - mask bit 0 enables receive data
// - mask bit 1 enables transmit ready
// - mask bit 2 enables line status
// - overrun raises line status at once
// - errors raise on read unless extra mode
// - mask bit 3 enables modem status
// - mask bit 4 sleep, enhanced-gated write
// - mask bit 5 xoff, enhanced-gated write
// - source read shows highest pending only
// - source bits 0-5 encode level, source
// - enhanced bit 4 unlocks fields; 0xBF gate
// - priority line, timeout, rx, tx, modem, xoff
// - source bit 0 low when pending
// - reads and writes clear their interrupts
package uart_irq_pkg;
  // register byte addresses (index times four)
  localparam logic [4:0] ADDR_HOLDING = 5'h00;
  localparam logic [4:0] ADDR_MASK = 5'h04;
  localparam logic [4:0] ADDR_SOURCE = 5'h08;
  localparam logic [4:0] ADDR_FORMAT = 5'h0c;
  localparam logic [4:0] ADDR_MODEM_CTL = 5'h10;
  localparam logic [4:0] ADDR_LINE = 5'h14;
  localparam logic [4:0] ADDR_MODEM = 5'h18;
  localparam logic [4:0] ADDR_EXTRA = 5'h1c;
  localparam logic [4:0] ADDR_RESUME1 = 5'h10;
  localparam logic [4:0] ADDR_RESUME2 = 5'h14;
  localparam logic [4:0] ADDR_PAUSE1 = 5'h18;
  localparam logic [4:0] ADDR_PAUSE2 = 5'h1c;
  localparam logic [7:0] ENHANCED_KEY = 8'hbf;
  localparam int UNLOCK_BIT = 4;
  localparam int EXTRA_IMMEDIATE_BIT = 6;
  localparam int FEATURE_CONTROL_SPACE_BIT = 6;
  localparam logic [7:0] MASK_BASIC = 8'h0f;
  localparam logic [7:0] MASK_ENH = 8'h30;
  // source codes, bits 5:0
  localparam logic [5:0] SRC_LINE = 6'h06;
  localparam logic [5:0] SRC_TIMEOUT = 6'h0c;
  localparam logic [5:0] SRC_RXDATA = 6'h04;
  localparam logic [5:0] SRC_TRANSMIT_READY_EVENT = 6'h02;
  localparam logic [5:0] SRC_MODEM = 6'h00;
  localparam logic [5:0] SRC_XOFF = 6'h10;
  localparam logic [5:0] SRC_NONE = 6'h01;
  localparam logic [31:0] READ_ZERO = 32'h0000_0000;

  // events and levels coming from the datapath
  typedef struct packed {
    logic rx_entry;      // character moved into receive fifo
    logic rx_empty;
    logic at_trigger;    // fifo level at or above trigger
    logic rx_timeout;
    logic overrun;
    logic [2:0] head_err; // break, framing, parity of head character
    logic any_err;       // errored character anywhere in fifo
    logic pop_err;       // errored character being read out
    logic new_err;       // errored character arriving
    logic thr_empty;
    logic all_empty;
    logic tx_event;      // holding empty / below trigger
    logic modem_delta;
    logic xoff_seen;
    logic xon_seen;
    logic wake;
    logic fifo_on;
  } link_in_t;

  // state of the block
  typedef struct packed {
    logic [7:0] mask;
    logic [7:0] enhanced_features;
    logic [7:0] feature_control;
    logic [7:0] trig;
    logic [7:0] extra;
    logic [7:0] fmt;
    logic [7:0] res1;
    logic [7:0] res2;
    logic [7:0] pau1;
    logic [7:0] pau2;
    logic rx_ready;
    logic line_pend;
    logic tx_pend;
    logic modem_pend;
    logic xoff_pend;
    logic wake_pend;
    logic dphase;
    logic dwrite;
    logic [4:0] daddr;
    logic [31:0] rdata;
  } state_t;
endpackage

// ### src/uart_irq.sv
// Decided for this implementation: register access over AHB-Lite.
`timescale 1ns/1ns
module uart_irq
  import uart_irq_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire link_in_t link,
  input wire logic [7:0] fifo_count,
  output logic rx_read,
  output logic tx_write,
  output logic [7:0] trigger_level,
  output logic sleep_enable,
  output logic irq
);
  state_t s_q;
  state_t s_d;
  logic take;
  logic unlocked;
  logic key_on;
  logic [4:0] a;
  logic wr;
  logic rd;
  logic line_bits;
  logic rx_src;
  logic [5:0] code;

  // address phase qualification
  assign take = hsel & hready & htrans[1];
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = s_q.rdata;
  assign trigger_level = s_q.trig;
  assign sleep_enable = s_q.mask[4];
  assign unlocked = s_q.enhanced_features[UNLOCK_BIT];
  assign key_on = (s_q.fmt == ENHANCED_KEY);
  assign a = s_q.daddr;
  assign wr = s_q.dphase & s_q.dwrite;
  assign rd = s_q.dphase & ~s_q.dwrite;
  assign rx_read = rd & ~key_on & (a == ADDR_HOLDING);
  assign tx_write = wr & ~key_on & (a == ADDR_HOLDING);

  // priority encoder over enabled pending sources
  always_comb begin
    line_bits = link.overrun | (|link.head_err);
    rx_src = link.fifo_on ? link.at_trigger : s_q.rx_ready;
    if (s_q.mask[2] & s_q.line_pend) begin
      code = SRC_LINE;
    end else if (s_q.mask[0] & link.rx_timeout) begin
      code = SRC_TIMEOUT;
    end else if (s_q.mask[0] & rx_src) begin
      code = SRC_RXDATA;
    end else if (s_q.mask[1] & s_q.tx_pend) begin
      code = SRC_TRANSMIT_READY_EVENT;
    end else if (s_q.mask[3] & s_q.modem_pend) begin
      code = SRC_MODEM;
    end else if (s_q.mask[5] & s_q.xoff_pend) begin
      code = SRC_XOFF;
    end else begin
      code = SRC_NONE;
    end
  end

  // irq while any enabled source pends; polled mode when mask 3:0 and mask 5 clear
  assign irq = ~code[0];

  // next state
  always_comb begin
    s_d = s_q;
    s_d.dphase = take;
    s_d.dwrite = hwrite;
    s_d.daddr = haddr[4:0];
    // receive ready: set on entry wins over empty
    if (link.rx_entry) begin
      s_d.rx_ready = 1'b1;
    end else if (link.rx_empty) begin
      s_d.rx_ready = 1'b0;
    end
    // other clears first, sets after so sets win
    if (rd & ~key_on & (a == ADDR_LINE)) begin
      s_d.line_pend = 1'b0;
    end
    if (rd & ~key_on & (a == ADDR_MODEM)) begin
      s_d.modem_pend = 1'b0;
    end
    if (tx_write | (rd & ~key_on & (a == ADDR_SOURCE))) begin
      s_d.tx_pend = 1'b0;
    end
    if ((rd & ~key_on & (a == ADDR_SOURCE)) | link.xon_seen) begin
      s_d.xoff_pend = 1'b0;
      s_d.wake_pend = 1'b0;
    end
    if (link.overrun) begin
      s_d.line_pend = 1'b1;
    end
    if (s_q.extra[EXTRA_IMMEDIATE_BIT] ? link.new_err : link.pop_err) begin
      s_d.line_pend = 1'b1;
    end
    if (line_bits & s_q.extra[EXTRA_IMMEDIATE_BIT]) begin
      s_d.line_pend = 1'b1;
    end
    if (link.tx_event) begin
      s_d.tx_pend = 1'b1;
    end
    if (link.modem_delta) begin
      s_d.modem_pend = 1'b1;
    end
    if (link.xoff_seen) begin
      s_d.xoff_pend = 1'b1;
    end
    if (link.wake) begin
      s_d.wake_pend = 1'b1;
    end
    // register writes
    if (wr) begin
      if (key_on) begin
        if (a == ADDR_SOURCE) begin
          s_d.enhanced_features = hwdata[7:0];
        end else if (a == ADDR_MASK) begin
          s_d.feature_control = hwdata[7:0];
        end else if (a == ADDR_HOLDING) begin
          s_d.trig = hwdata[7:0];
        end else if (a == ADDR_FORMAT) begin
          s_d.fmt = hwdata[7:0];
        end else if (a == ADDR_RESUME1) begin
          s_d.res1 = hwdata[7:0];
        end else if (a == ADDR_RESUME2) begin
          s_d.res2 = hwdata[7:0];
        end else if (a == ADDR_PAUSE1) begin
          s_d.pau1 = hwdata[7:0];
        end else if (a == ADDR_PAUSE2) begin
          s_d.pau2 = hwdata[7:0];
        end
      end else if (a == ADDR_MASK) begin
        s_d.mask = hwdata[7:0] & (unlocked ? (MASK_BASIC | MASK_ENH) : MASK_BASIC);
        if (~unlocked) begin
          s_d.mask[5:4] = s_q.mask[5:4];
        end
        if (hwdata[1] & ~s_q.mask[1] & link.thr_empty) begin
          s_d.tx_pend = 1'b1;
        end
      end else if (a == ADDR_FORMAT) begin
        s_d.fmt = hwdata[7:0];
      end else if (a == ADDR_EXTRA & s_q.feature_control[FEATURE_CONTROL_SPACE_BIT]) begin
        s_d.extra = hwdata[7:0];
      end
    end
    // read data, captured on the address phase
    s_d.rdata = READ_ZERO;
    if (take & ~hwrite) begin
      if (key_on) begin
        if (haddr[4:0] == ADDR_HOLDING) begin
          s_d.rdata[7:0] = fifo_count;
        end else if (haddr[4:0] == ADDR_MASK) begin
          s_d.rdata[7:0] = s_q.feature_control;
        end else if (haddr[4:0] == ADDR_SOURCE) begin
          s_d.rdata[7:0] = s_q.enhanced_features;
        end else if (haddr[4:0] == ADDR_FORMAT) begin
          s_d.rdata[7:0] = s_q.fmt;
        end else if (haddr[4:0] == ADDR_RESUME1) begin
          s_d.rdata[7:0] = s_q.res1;
        end else if (haddr[4:0] == ADDR_RESUME2) begin
          s_d.rdata[7:0] = s_q.res2;
        end else if (haddr[4:0] == ADDR_PAUSE1) begin
          s_d.rdata[7:0] = s_q.pau1;
        end else if (haddr[4:0] == ADDR_PAUSE2) begin
          s_d.rdata[7:0] = s_q.pau2;
        end
      end else if (haddr[4:0] == ADDR_MASK) begin
        s_d.rdata[7:0] = s_q.mask;
      end else if (haddr[4:0] == ADDR_SOURCE) begin
        s_d.rdata[7:6] = {2{link.fifo_on}};
        s_d.rdata[5:0] = (code == SRC_NONE && s_q.wake_pend) ? SRC_NONE : code;
        if (~unlocked) begin
          s_d.rdata[5:4] = 2'b00;
        end
      end else if (haddr[4:0] == ADDR_FORMAT) begin
        s_d.rdata[7:0] = s_q.fmt;
      end else if (haddr[4:0] == ADDR_LINE) begin
        s_d.rdata[0] = s_q.rx_ready;
        s_d.rdata[1] = link.overrun;
        s_d.rdata[4:2] = link.head_err;
        s_d.rdata[5] = link.thr_empty;
        s_d.rdata[6] = link.all_empty;
        s_d.rdata[7] = link.any_err;
      end
    end
  end

  // state register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_q <= '0; // masks reset disabled
    end else begin
      s_q <= s_d;
    end
  end
endmodule // uart_irq

// ### testbench/uart_irq_checker.sv
`timescale 1ns/1ns
module uart_irq_checker
  import uart_irq_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic [31:0] hrdata,
  input wire link_in_t link,
  input wire logic rx_read,
  input wire logic tx_write,
  input wire logic sleep_enable,
  input wire logic irq
);
  logic wr_q, rd_q;
  logic [4:0] ad_q;
  logic [7:0] fmt_q;
  logic [3:0] msk_q;
  wire norm = fmt_q != ENHANCED_KEY;
  wire src_rd = rd_q && ad_q == ADDR_SOURCE && norm;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // shadow of data phase, format and basic mask
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      {wr_q, rd_q, ad_q, fmt_q, msk_q} <= '0;
    end else begin
      wr_q <= hsel && htrans[1] && hwrite;
      rd_q <= hsel && htrans[1] && !hwrite;
      ad_q <= haddr[4:0];
      if (wr_q && ad_q == ADDR_FORMAT) fmt_q <= hwdata[7:0];
      if (wr_q && ad_q == ADDR_MASK && norm) msk_q <= hwdata[3:0];
    end
  end
  a_reset_quiet: assert property ($rose(hresetn) |-> !irq && !sleep_enable)
    else $error("active after reset");
  a_rx_read_cause: assert property (rx_read |-> rd_q && ad_q == ADDR_HOLDING && norm)
    else $error("stray receive read");
  a_tx_write_cause: assert property (tx_write |-> wr_q && ad_q == ADDR_HOLDING && norm)
    else $error("stray transmit write");
  a_upper_zero: assert property (hrdata[31:8] == 24'h00_0000)
    else $error("upper read bits set");
  a_src_pending: assert property (src_rd && $past(irq) |-> !hrdata[0])
    else $error("pending not shown");
  a_sleep_cause: assert property ($changed(sleep_enable) |-> $past(wr_q && ad_q == ADDR_MASK))
    else $error("sleep changed alone");
  a_overrun_irq: assert property (msk_q[2] && link.overrun |=> irq)
    else $error("overrun not raised");
  a_tx_irq: assert property (wr_q && ad_q == ADDR_MASK && norm && hwdata[1] && link.thr_empty |-> ##[1:2] irq)
    else $error("transmit ready missing");
endmodule // uart_irq_checker

// ### testbench/uart_link_model.sv
`timescale 1ns/1ns
module uart_link_model
  import uart_irq_pkg::*;
(
  input wire logic hclk,
  input wire logic rx_read,
  input wire logic [7:0] trigger_level,
  output link_in_t link,
  output logic [7:0] fifo_count
);
  logic [2:0] err_q = 3'h0;
  initial begin
    link = '0;
    link.thr_empty = 1'b1;
    link.all_empty = 1'b1;
    fifo_count = 8'h00;
  end
  // levels follow the fifo count and head character
  always @(fifo_count or err_q or trigger_level) begin
    link.rx_empty = fifo_count == 8'h00;
    link.at_trigger = fifo_count != 8'h00 && fifo_count >= trigger_level;
    link.head_err = err_q;
    link.any_err = |err_q;
  end
  // host reads pop the head and flag its errors
  always @(posedge hclk) begin
    link.pop_err <= rx_read && |err_q;
    if (rx_read) err_q <= 3'h0;
    if (rx_read && fifo_count != 8'h00) fifo_count <= fifo_count - 8'h01;
  end
  task automatic push(input logic [2:0] e);
    link.rx_entry <= 1'b1;
    link.new_err <= |e;
    fifo_count <= fifo_count + 8'h01;
    if (fifo_count == 8'h00) err_q <= e;
    @(posedge hclk);
    link.rx_entry <= 1'b0;
    link.new_err <= 1'b0;
  endtask
endmodule // uart_link_model

// ### testbench/test_uart_interrupt_mask_and_status.sv
`timescale 1ns/1ns
module test_uart_interrupt_mask_and_status;
  import uart_irq_pkg::*;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'b00;
  logic [2:0] hsize = 3'b010; // word transfers only, driven by the bench
  logic [31:0] haddr = 32'h0000_0000;
  logic [31:0] hwdata = 32'h0000_0000;
  logic hreadyout, hresp, rx_read, tx_write, sleep_enable, irq;
  logic [31:0] hrdata;
  logic [7:0] trigger_level, fifo_count, q;
  link_in_t link;
  int n_fail = 0;
  int samples_checked = 0;
  uart_irq u_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hreadyout, .hresp, .hrdata, .link, .fifo_count, .rx_read, .tx_write,
    .trigger_level, .sleep_enable, .irq);
  uart_link_model u_link (.hclk, .rx_read, .trigger_level, .link, .fifo_count);
  initial forever #4 hclk = ~hclk;
  task automatic print_verdict;
    $display("checked %0d failed %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    samples_checked++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  // one single transfer; returns just after its data phase edge
  task automatic bus(input logic [4:0] a, input logic w, input logic [7:0] d);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {27'h000_0000, a};
    hwrite <= w;
    @(posedge hclk);
    while (!hreadyout) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= {24'h00_0000, d};
    @(posedge hclk);
    while (!hreadyout) @(posedge hclk);
    q = hrdata[7:0];
  endtask
  task automatic rd(input logic [4:0] a, input logic [7:0] m, input logic [7:0] e);
    bus(a, 1'b0, 8'h00);
    chk(q & m, e);
  endtask
  task automatic see(input logic e);
    #1 chk({7'h00, irq}, {7'h00, e});
  endtask
  task automatic t_enh;
    rd(ADDR_SOURCE, 8'h3f, {2'b00, SRC_NONE});
    bus(ADDR_MASK, 1'b1, 8'h30);
    rd(ADDR_MASK, 8'hff, 8'h00);
    bus(ADDR_FORMAT, 1'b1, ENHANCED_KEY);
    bus(ADDR_SOURCE, 1'b1, 8'h10);
    bus(ADDR_HOLDING, 1'b1, 8'h02);
    rd(ADDR_SOURCE, 8'hff, 8'h10);
    chk(trigger_level, 8'h02);
    bus(ADDR_FORMAT, 1'b1, 8'h03);
    bus(ADDR_MASK, 1'b1, 8'h10);
    see(1'b0);
    chk({7'h00, sleep_enable}, 8'h01);
  endtask
  task automatic t_tx;
    bus(ADDR_MASK, 1'b1, 8'h02);
    see(1'b1);
    rd(ADDR_SOURCE, 8'h3f, {2'b00, SRC_TRANSMIT_READY_EVENT});
    see(1'b0);
  endtask
  task automatic t_rx;
    bus(ADDR_MASK, 1'b1, 8'h00);
    u_link.link.fifo_on <= 1'b1;
    u_link.push(3'b000);
    repeat (2) @(posedge hclk);
    see(1'b0);
    rd(ADDR_LINE, 8'hff, 8'h61);
    bus(ADDR_MASK, 1'b1, 8'h01);
    see(1'b0);
    u_link.push(3'b000);
    repeat (2) @(posedge hclk);
    see(1'b1);
    rd(ADDR_SOURCE, 8'h3f, {2'b00, SRC_RXDATA});
    bus(ADDR_HOLDING, 1'b0, 8'h00);
    repeat (2) @(posedge hclk);
    see(1'b0);
    bus(ADDR_HOLDING, 1'b0, 8'h00);
    repeat (2) @(posedge hclk);
    rd(ADDR_LINE, 8'h01, 8'h00);
  endtask
  task automatic t_line;
    bus(ADDR_MASK, 1'b1, 8'h05);
    u_link.push(3'b001);
    repeat (3) @(posedge hclk);
    see(1'b0);
    bus(ADDR_HOLDING, 1'b0, 8'h00);
    repeat (3) @(posedge hclk);
    see(1'b1);
    u_link.push(3'b000);
    u_link.push(3'b000);
    repeat (2) @(posedge hclk);
    rd(ADDR_SOURCE, 8'h3f, {2'b00, SRC_LINE});
    bus(ADDR_LINE, 1'b0, 8'h00);
    rd(ADDR_SOURCE, 8'h3f, {2'b00, SRC_RXDATA});
    u_link.link.overrun <= 1'b1;
    repeat (2) @(posedge hclk);
    // overrun flag is a live level, so keep it up across both reads
    rd(ADDR_SOURCE, 8'h3f, {2'b00, SRC_LINE});
    rd(ADDR_LINE, 8'h02, 8'h02);
    u_link.link.overrun <= 1'b0;
  endtask
  // reset, then the scenarios in turn
  initial begin
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    t_enh;
    t_tx;
    t_rx;
    t_line;
    print_verdict;
  end
  // watchdog against a hung transfer
  initial begin
    #20000;
    n_fail++;
    print_verdict;
  end
endmodule // test_uart_interrupt_mask_and_status
bind uart_irq uart_irq_checker u_chk (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata,
  .hrdata, .link, .rx_read, .tx_write, .sleep_enable, .irq);
